// ---- rtl/bjc_params.svh ----
// constants of the burner jumper configuration and timing block
// assumes a 100 MHz aclk; included by bjc_top
`ifndef BJC_PARAMS_SVH
`define BJC_PARAMS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define BJC_ADDR_W 8
`define BJC_CTRL_OFS 8'h00
`define BJC_STATUS_OFS 8'h04
`define BJC_IRQ_STAT_OFS 8'h08
`define BJC_IRQ_MASK_OFS 8'h0c
`define BJC_CONFIG_OFS 8'h10
`define BJC_RUNTIME_OFS 8'h14
`define BJC_RESP_OKAY 2'h0
`define BJC_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define BJC_CTRL_START_BIT 0
`define BJC_CTRL_STOP_BIT 1
`define BJC_ST_STATE_LSB 0
`define BJC_ST_FLAME_BIT 4
`define BJC_ST_SHUTDOWN_BIT 5
`define BJC_ST_LOCKOUT_BIT 6
`define BJC_ST_FAULT_LSB 8
`define BJC_ST_STRAPS_LSB 16
`define BJC_ST_LIVE_STRAPS_LSB 20
`define BJC_CFG_PILOT_FLAME_ESTABLISH_PERIOD_LSB 0
`define BJC_CFG_MAIN_FLAME_ESTABLISH_PERIOD_LSB 8
`define BJC_CFG_INTERRUPT_BIT 16
`define BJC_CFG_CHECK_BIT 17
`define BJC_CFG_LINK_BIT 18
`define BJC_IRQ_W 4
`define BJC_IRQ_SHUTDOWN 0
`define BJC_IRQ_LOCKOUT 1
`define BJC_IRQ_STRAP 2
`define BJC_IRQ_RUN 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BJC_IRQ_MASK_RST 4'h0
`define BJC_FAULT_NONE 8'h00
`define BJC_FAULT_JUMPER 8'h6e

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BJC_CLK_PERIOD_NS 32'h0000000a
`define BJC_NS_PER_S 32'h3b9aca00
`define BJC_CYC_PER_S (`BJC_NS_PER_S / `BJC_CLK_PERIOD_NS)
`define BJC_S_PER_HOUR 32'h00000e10
`define BJC_LOCKOUT_HOURS 32'h000000c8
`define BJC_PILOT_FLAME_ESTABLISH_PERIOD_LONG_S 6'h0a
`define BJC_PILOT_FLAME_ESTABLISH_PERIOD_SHORT_S 6'h04
`define BJC_MAIN_FLAME_ESTABLISH_PERIOD_INTERMIT_S 6'h0a
`define BJC_MAIN_FLAME_ESTABLISH_PERIOD_INTERRUPT_S 6'h0f
`define BJC_MAIN_FLAME_ESTABLISH_PERIOD_EXTENDED_S 6'h1e
`define BJC_PILOT_OFF_S 6'h0f
`define BJC_SETTLE_CYC 3'h6

`endif

// ---- rtl/bjc_pkg.sv ----
// types of the burner jumper configuration and timing block
// assumes nothing beyond the params header
package bjc_pkg;
	typedef enum logic [2:0] {
		BJC_IDLE,
		BJC_PILOT,
		BJC_MAIN,
		BJC_RUN,
		BJC_SHUTDOWN,
		BJC_LOCKOUT
	} bjc_state_e;
	typedef logic [2:0] bjc_sel_t;
endpackage

// ---- rtl/bjc_sync.sv ----
// three flop input synchroniser with agreement filter
// assumes asynchronous pin inputs and one clock aclk
`timescale 1ns/1ps
module bjc_sync #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_reg, s2_reg, s3_reg, out_reg;
			logic out_next;
			// change taken once stages two and three agree
			always_comb begin
				out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
			end
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
					s3_reg <= 1'b0;
					out_reg <= 1'b0;
				end else begin
					s1_reg <= din[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					out_reg <= out_next;
				end
			end
			assign dout[i] = out_reg;
		end
	endgenerate
endmodule // bjc_sync

// ---- rtl/bjc_top.sv ----
// burner jumper configuration and ignition trial timing, axi4-lite slave
// assumes 100 MHz aclk, straps and flame sense are asynchronous pins
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "bjc_params.svh"
module bjc_top #(
	parameter int CYC_PER_S = `BJC_CYC_PER_S,
	parameter int S_PER_HOUR = `BJC_S_PER_HOUR
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pilot_period_select_strap,
	input wire logic pilot_valve_mode_strap,
	input wire logic interlock_check_strap,
	input wire logic blower_link_sense,
	input wire logic flame_sense,
	output logic pilot_valve,
	output logic main_valve,
	output logic interlock_check_en,
	output logic safety_shutdown,
	output logic hard_lockout,
	output logic irq
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [4:0] pins_s;
	bjc_sync #(.W(5)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din({flame_sense, blower_link_sense, interlock_check_strap, pilot_valve_mode_strap,
			pilot_period_select_strap}),
		.dout(pins_s)
	);
	logic [2:0] straps_live;
	logic link_s, flame_s;
	assign straps_live = pins_s[2:0];
	assign link_s = pins_s[3];
	assign flame_s = pins_s[4];

	function automatic bjc_pkg::bjc_sel_t reg_sel(input logic [7:0] a);
		case (a)
			`BJC_CTRL_OFS: reg_sel = 3'h0;
			`BJC_STATUS_OFS: reg_sel = 3'h1;
			`BJC_IRQ_STAT_OFS: reg_sel = 3'h2;
			`BJC_IRQ_MASK_OFS: reg_sel = 3'h3;
			`BJC_CONFIG_OFS: reg_sel = 3'h4;
			`BJC_RUNTIME_OFS: reg_sel = 3'h5;
			default: reg_sel = 3'h7;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	bjc_pkg::bjc_state_e state_reg, state_next;
	logic [2:0] settle_reg, settle_next, straps_reg, straps_next;
	logic latched_reg, latched_next, strap_seen_reg, strap_seen_next;
	logic [26:0] pre_reg, pre_next;
	logic [5:0] sec_reg, sec_next;
	logic [31:0] runtime_reg, runtime_next;
	logic pilot_reg, pilot_next, main_reg, main_next, check_reg, check_next;
	logic shut_reg, shut_next, lock_reg, lock_next;
	logic [7:0] fault_reg, fault_next;
	logic [3:0] istat_reg, istat_next, imask_reg, imask_next;
	logic irq_reg, irq_next;
	logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
	logic [7:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic bvalid_reg, bvalid_next, awready_reg, awready_next, wready_reg, wready_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic arready_reg, arready_next, rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;

	logic wr_fire, rd_fire, start_cmd, stop_cmd, tick, over_hours, strap_removed;
	logic [5:0] pilot_flame_establish_period_s, main_flame_establish_period_s, pilot_off_s, sec_inc;
	logic [3:0] ev;
	logic [31:0] status_word, config_word;

	// ----------------------------------------------------------------
	// configuration decode
	// ----------------------------------------------------------------
	always_comb begin
		pilot_flame_establish_period_s = straps_reg[0] ? `BJC_PILOT_FLAME_ESTABLISH_PERIOD_LONG_S : `BJC_PILOT_FLAME_ESTABLISH_PERIOD_SHORT_S;
		if (straps_reg[1]) begin
			main_flame_establish_period_s = `BJC_MAIN_FLAME_ESTABLISH_PERIOD_INTERMIT_S;
		end else begin
			main_flame_establish_period_s = link_s ? `BJC_MAIN_FLAME_ESTABLISH_PERIOD_EXTENDED_S : `BJC_MAIN_FLAME_ESTABLISH_PERIOD_INTERRUPT_S;
		end
		pilot_off_s = link_s ? `BJC_MAIN_FLAME_ESTABLISH_PERIOD_EXTENDED_S : `BJC_PILOT_OFF_S;
		over_hours = runtime_reg > 32'(`BJC_LOCKOUT_HOURS * S_PER_HOUR);
		strap_removed = latched_reg && ((straps_reg & ~straps_live) != 3'h0);
		tick = pre_reg == 27'(CYC_PER_S - 1);
		sec_inc = (sec_reg == 6'h3f) ? sec_reg : sec_reg + 6'h01;
		status_word = 32'h0;
		status_word[`BJC_ST_STATE_LSB +: 3] = state_reg;
		status_word[`BJC_ST_FLAME_BIT] = flame_s;
		status_word[`BJC_ST_SHUTDOWN_BIT] = shut_reg;
		status_word[`BJC_ST_LOCKOUT_BIT] = lock_reg;
		status_word[`BJC_ST_FAULT_LSB +: 8] = fault_reg;
		status_word[`BJC_ST_STRAPS_LSB +: 3] = straps_reg;
		status_word[`BJC_ST_LIVE_STRAPS_LSB +: 3] = straps_live;
		config_word = 32'h0;
		config_word[`BJC_CFG_PILOT_FLAME_ESTABLISH_PERIOD_LSB +: 6] = pilot_flame_establish_period_s;
		config_word[`BJC_CFG_MAIN_FLAME_ESTABLISH_PERIOD_LSB +: 6] = main_flame_establish_period_s;
		config_word[`BJC_CFG_INTERRUPT_BIT] = ~straps_reg[1];
		config_word[`BJC_CFG_CHECK_BIT] = check_reg;
		config_word[`BJC_CFG_LINK_BIT] = link_s;
	end

	// ----------------------------------------------------------------
	// axi4-lite slave
	// ----------------------------------------------------------------
	always_comb begin
		aw_full_next = aw_full_reg;
		awaddr_next = awaddr_reg;
		w_full_next = w_full_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (s_axi_awvalid && awready_reg) begin
			aw_full_next = 1'b1;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_reg) begin
			w_full_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
		end
		wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
		start_cmd = wr_fire && reg_sel(awaddr_reg) == 3'h0 && wstrb_reg[0] && wdata_reg[`BJC_CTRL_START_BIT];
		stop_cmd = wr_fire && reg_sel(awaddr_reg) == 3'h0 && wstrb_reg[0] && wdata_reg[`BJC_CTRL_STOP_BIT];
		if (wr_fire) begin
			aw_full_next = 1'b0;
			w_full_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = (reg_sel(awaddr_reg) == 3'h7) ? `BJC_RESP_SLVERR : `BJC_RESP_OKAY;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		awready_next = !aw_full_next && !bvalid_next;
		wready_next = !w_full_next && !bvalid_next;
		rd_fire = s_axi_arvalid && arready_reg;
		if (rd_fire) begin
			rvalid_next = 1'b1;
			rresp_next = `BJC_RESP_OKAY;
			case (reg_sel(s_axi_araddr))
				3'h0: rdata_next = 32'h0;
				3'h1: rdata_next = status_word;
				3'h2: rdata_next = {28'h0, istat_reg};
				3'h3: rdata_next = {28'h0, imask_reg};
				3'h4: rdata_next = config_word;
				3'h5: rdata_next = runtime_reg;
				default: begin
					rdata_next = 32'h0;
					rresp_next = `BJC_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		arready_next = !rvalid_next;
	end

	// ----------------------------------------------------------------
	// sequencer, strap supervision, interrupts
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		settle_next = settle_reg;
		straps_next = straps_reg;
		latched_next = latched_reg;
		strap_seen_next = strap_seen_reg;
		lock_next = lock_reg;
		fault_next = fault_reg;
		shut_next = shut_reg;
		imask_next = imask_reg;
		ev = 4'h0;
		// latch straps once the synchronisers have settled
		if (!latched_reg) begin
			settle_next = settle_reg + 3'h1;
			if (settle_reg == `BJC_SETTLE_CYC) begin
				straps_next = straps_live;
				latched_next = 1'b1;
			end
		end
		if (strap_removed && !strap_seen_reg) begin
			strap_seen_next = 1'b1;
			ev[`BJC_IRQ_STRAP] = 1'b1;
		end
		case (state_reg)
			bjc_pkg::BJC_IDLE, bjc_pkg::BJC_SHUTDOWN: begin
				if (start_cmd && latched_reg) begin
					state_next = bjc_pkg::BJC_PILOT;
					shut_next = 1'b0;
				end
			end
			bjc_pkg::BJC_PILOT: begin
				if (stop_cmd) begin
					state_next = bjc_pkg::BJC_IDLE;
				end else if (tick && sec_inc == pilot_flame_establish_period_s) begin
					state_next = flame_s ? bjc_pkg::BJC_MAIN : bjc_pkg::BJC_SHUTDOWN;
				end
			end
			bjc_pkg::BJC_MAIN: begin
				if (stop_cmd) begin
					state_next = bjc_pkg::BJC_IDLE;
				end else if (!flame_s) begin
					state_next = bjc_pkg::BJC_SHUTDOWN;
				end else if (tick && sec_inc == main_flame_establish_period_s) begin
					state_next = bjc_pkg::BJC_RUN;
					ev[`BJC_IRQ_RUN] = 1'b1;
				end
			end
			bjc_pkg::BJC_RUN: begin
				if (stop_cmd) begin
					state_next = bjc_pkg::BJC_IDLE;
				end else if (!flame_s) begin
					state_next = bjc_pkg::BJC_SHUTDOWN;
				end
			end
			bjc_pkg::BJC_LOCKOUT: state_next = bjc_pkg::BJC_LOCKOUT;
			default: state_next = bjc_pkg::BJC_IDLE;
		endcase
		if (state_next == bjc_pkg::BJC_SHUTDOWN && state_reg != bjc_pkg::BJC_SHUTDOWN) begin
			shut_next = 1'b1;
			ev[`BJC_IRQ_SHUTDOWN] = 1'b1;
		end
		if (strap_removed && over_hours && !lock_reg) begin
			state_next = bjc_pkg::BJC_LOCKOUT;
			lock_next = 1'b1;
			fault_next = `BJC_FAULT_JUMPER;
			ev[`BJC_IRQ_LOCKOUT] = 1'b1;
		end
		// timers restart on every state change; run keeps counting since main opened
		if (state_next != state_reg && state_next != bjc_pkg::BJC_RUN) begin
			pre_next = 27'h0;
			sec_next = 6'h0;
		end else begin
			pre_next = tick ? 27'h0 : pre_reg + 27'h1;
			sec_next = tick ? sec_inc : sec_reg;
		end
		runtime_next = (tick && main_reg && runtime_reg != 32'hffffffff) ? runtime_reg + 32'h1 : runtime_reg;
		main_next = state_next == bjc_pkg::BJC_MAIN || state_next == bjc_pkg::BJC_RUN;
		pilot_next = state_next == bjc_pkg::BJC_PILOT ||
			(main_next && (straps_reg[1] || sec_next < pilot_off_s));
		check_next = ~straps_reg[2];
		if (wr_fire && reg_sel(awaddr_reg) == 3'h3 && wstrb_reg[0]) begin
			imask_next = wdata_reg[`BJC_IRQ_W-1:0];
		end
		// read clears, a new event in the same cycle survives
		istat_next = ((rd_fire && reg_sel(s_axi_araddr) == 3'h2) ? 4'h0 : istat_reg) | ev;
		irq_next = (istat_next & imask_next) != 4'h0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= bjc_pkg::BJC_IDLE;
			settle_reg <= 3'h0;
			straps_reg <= 3'h7;
			latched_reg <= 1'b0;
			strap_seen_reg <= 1'b0;
			pre_reg <= 27'h0;
			sec_reg <= 6'h0;
			runtime_reg <= 32'h0;
			pilot_reg <= 1'b0;
			main_reg <= 1'b0;
			check_reg <= 1'b0;
			shut_reg <= 1'b0;
			lock_reg <= 1'b0;
			fault_reg <= `BJC_FAULT_NONE;
			istat_reg <= 4'h0;
			imask_reg <= `BJC_IRQ_MASK_RST;
			irq_reg <= 1'b0;
			aw_full_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			w_full_reg <= 1'b0;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `BJC_RESP_OKAY;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= `BJC_RESP_OKAY;
		end else begin
			state_reg <= state_next;
			settle_reg <= settle_next;
			straps_reg <= straps_next;
			latched_reg <= latched_next;
			strap_seen_reg <= strap_seen_next;
			pre_reg <= pre_next;
			sec_reg <= sec_next;
			runtime_reg <= runtime_next;
			pilot_reg <= pilot_next;
			main_reg <= main_next;
			check_reg <= check_next;
			shut_reg <= shut_next;
			lock_reg <= lock_next;
			fault_reg <= fault_next;
			istat_reg <= istat_next;
			imask_reg <= imask_next;
			irq_reg <= irq_next;
			aw_full_reg <= aw_full_next;
			awaddr_reg <= awaddr_next;
			w_full_reg <= w_full_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign pilot_valve = pilot_reg;
	assign main_valve = main_reg;
	assign interlock_check_en = check_reg;
	assign safety_shutdown = shut_reg;
	assign hard_lockout = lock_reg;
	assign irq = irq_reg;
endmodule // bjc_top

// ---- verification/bjc_burner_model.sv ----
// behavioural burner: flame lights from the pilot, main holds it
// assumes lights is commanded by the bench
`timescale 1ns/1ps
module bjc_burner_model (
	input wire logic aclk,
	input wire logic pilot_valve,
	input wire logic main_valve,
	input wire logic lights,
	output logic flame_sense
);
	// ----------------------------------------------------------------
	// ignition delay and flame hold
	// ----------------------------------------------------------------
	logic [1:0] dly = 2'h0;
	initial flame_sense = 1'b0;
	always @(posedge aclk) begin
		dly <= (pilot_valve && lights) ? ((dly == 2'h3) ? dly : dly + 2'h1) : 2'h0;
		flame_sense <= lights && (dly == 2'h3 || (flame_sense && main_valve));
	end
endmodule // bjc_burner_model

// ---- verification/bjc_top_sva.sv ----
// checker of ignition timing and strap handling at the bjc_top ports
// assumes bound into bjc_top, small CYC_PER_S in simulation
`timescale 1ns/1ps
module bjc_top_chk #(
	parameter int CYC_PER_S = 10,
	parameter int S_PER_HOUR = 2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pilot_valve_mode_strap,
	input wire logic blower_link_sense,
	input wire logic pilot_valve,
	input wire logic main_valve,
	input wire logic interlock_check_en,
	input wire logic safety_shutdown,
	input wire logic hard_lockout
);
	// ----------------------------------------------------------------
	// helper counters and properties
	// ----------------------------------------------------------------
	localparam int PMIN = 4 * CYC_PER_S - 4;
	localparam int PMAX = 10 * CYC_PER_S + 4;
	logic [15:0] pil_cnt;
	logic [15:0] main_cnt;
	logic [3:0] rst_cnt;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pil_cnt <= '0;
			main_cnt <= '0;
			rst_cnt <= '0;
		end else begin
			pil_cnt <= (pilot_valve && !main_valve) ? pil_cnt + 16'h1 : '0;
			main_cnt <= main_valve ? main_cnt + 16'h1 : '0;
			rst_cnt <= (rst_cnt == 4'hf) ? rst_cnt : rst_cnt + 4'h1;
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_pilot_len;
		$rose(main_valve) |-> pil_cnt >= PMIN && pil_cnt <= PMAX;
	endproperty
	a_pilot_len: assert property (p_pilot_len) else $error("main valve opened off the pilot period");
	property p_pilot_end;
		pil_cnt <= PMAX + 4;
	endproperty
	a_pilot_end: assert property (p_pilot_end) else $error("pilot trial ran past its period");
	property p_int_pilot;
		$fell(pilot_valve) && main_valve |-> !pilot_valve_mode_strap;
	endproperty
	a_int_pilot: assert property (p_int_pilot) else $error("intermittent pilot dropped");
	property p_pilot_drop;
		$fell(pilot_valve) && main_valve && !blower_link_sense |->
			main_cnt >= 15 * CYC_PER_S - 4 && main_cnt <= 15 * CYC_PER_S + 4;
	endproperty
	a_pilot_drop: assert property (p_pilot_drop) else $error("pilot drop time wrong");
	property p_link_drop;
		$fell(pilot_valve) && main_valve && blower_link_sense |->
			main_cnt >= 30 * CYC_PER_S - 4 && main_cnt <= 30 * CYC_PER_S + 4;
	endproperty
	a_link_drop: assert property (p_link_drop) else $error("linked pilot drop time wrong");
	property p_il_stable;
		rst_cnt >= 4'hc |-> $stable(interlock_check_en);
	endproperty
	a_il_stable: assert property (p_il_stable) else $error("check enable moved after latch");
	property p_lock_sticky;
		$rose(hard_lockout) |=> hard_lockout [*8];
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("lockout released");
	property p_lock_valves;
		hard_lockout |-> ##2 (!main_valve && !pilot_valve);
	endproperty
	a_lock_valves: assert property (p_lock_valves) else $error("valves open in lockout");
	c_main: cover property ($rose(main_valve));
	c_drop: cover property ($fell(pilot_valve) && main_valve);
	c_shut: cover property ($rose(safety_shutdown));
	c_lock: cover property ($rose(hard_lockout));
endmodule // bjc_top_chk

bind bjc_top bjc_top_chk #(.CYC_PER_S(CYC_PER_S), .S_PER_HOUR(S_PER_HOUR)) u_chk (.aclk(aclk),
	.aresetn(aresetn), .pilot_valve_mode_strap(pilot_valve_mode_strap), .blower_link_sense(blower_link_sense),
	.pilot_valve(pilot_valve), .main_valve(main_valve), .interlock_check_en(interlock_check_en),
	.safety_shutdown(safety_shutdown), .hard_lockout(hard_lockout));

// ---- verification/tb_top.sv ----
// self-checking bench of the burner jumper configuration block
// assumes bjc_top with checker bound, bjc_burner_model as burner
`timescale 1ns/1ps
module tb_top;
	// ----------------------------------------------------------------
	// signals, tasks and sequence
	// ----------------------------------------------------------------
	localparam int C = 10;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic bready = 1'b1;
	logic rready = 1'b1;
	logic s1 = 1'b1;
	logic s2 = 1'b1;
	logic s3 = 1'b1;
	logic link = 1'b0;
	logic lights = 1'b0;
	logic [31:0] rnd = 32'h9c03d0d8;
	logic awready, wready, bvalid, arready, rvalid, flame, pilot, main, il_en, shut, lock, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int fail_count = 0;
	int compares = 0;
	initial forever #5 aclk = ~aclk;
	bjc_top #(.CYC_PER_S(C), .S_PER_HOUR(2)) uut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pilot_period_select_strap(s1), .pilot_valve_mode_strap(s2),
		.interlock_check_strap(s3), .blower_link_sense(link), .flame_sense(flame), .pilot_valve(pilot),
		.main_valve(main), .interlock_check_en(il_en), .safety_shutdown(shut), .hard_lockout(lock), .irq(irq));
	bjc_burner_model u_burner (.aclk(aclk), .pilot_valve(pilot), .main_valve(main), .lights(lights),
		.flame_sense(flame));
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction
	function automatic logic [5:0] pf();
		return s1 ? 6'h0a : 6'h04;
	endfunction
	function automatic logic [5:0] mf();
		return s2 ? 6'h0a : (link ? 6'h1e : 6'h0f);
	endfunction
	function automatic logic [31:0] near(input int a, input int b);
		return (a >= b - 4 && a <= b + 4) ? 32'h1 : 32'h0;
	endfunction
	function automatic logic sig(input int k);
		case (k)
			0: return pilot;
			1: return main;
			2: return irq;
			3: return shut;
			default: return lock;
		endcase
	endfunction
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task end_sim;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		r = 2'h3;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (r == 2'h3) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) r = bresp;
		end
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		r = 2'h3;
		araddr <= a;
		arvalid <= 1'b1;
		while (r == 2'h3) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			d = rdata;
			if (rvalid) r = rresp;
		end
	endtask
	task automatic wt(input int k, input int m, output int n);
		n = 0;
		while (sig(k) !== 1'b1 && n < m) begin
			@(posedge aclk);
			n++;
		end
	endtask
	task automatic boot(input logic a, input logic b, input logic c, input logic l);
		s1 <= a;
		s2 <= b;
		s3 <= c;
		link <= l;
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (12) @(posedge aclk);
	endtask
	task automatic t_cfg;
		logic [31:0] v;
		logic [1:0] r;
		rd(8'h10, v, r);
		chk("config", v, {13'h0, link, ~s3, ~s2, 2'h0, mf(), 2'h0, pf()});
		chk("check_en", il_en, !s3);
		rd(8'h0c, v, r);
		chk("mask_rst", v, 32'h0);
		rnd = xs(rnd);
		wr(8'h0c, rnd, r);
		rd(8'h0c, v, r);
		chk("mask", v, {28'h0, rnd[3:0]});
		// lane 0 strobe low must leave the mask alone
		wstrb <= 4'h0;
		wr(8'h0c, ~rnd, r);
		wstrb <= 4'hf;
		rd(8'h0c, v, r);
		chk("mask_strb", v, {28'h0, rnd[3:0]});
		rd(8'h18, v, r);
		chk("bad_rd", r, 2'h2);
		wr(8'h1c, 32'h5, r);
		chk("bad_wr", r, 2'h2);
		$display("config test done");
	endtask
	task automatic t_noflame;
		logic [31:0] v;
		logic [1:0] r;
		int n;
		wr(8'h0c, 32'h0, r);
		lights <= 1'b0;
		wr(8'h00, 32'h1, r);
		wt(0, 50, n);
		wt(3, 200, n);
		chk("shut_time", near(n, pf() * C), 32'h1);
		chk("shut_valve", {main, irq}, 2'h0);
		rd(8'h08, v, r);
		chk("shut_irq", v[0], 1'b1);
		$display("no flame test done");
	endtask
	task automatic t_burn;
		logic [31:0] v;
		logic [1:0] r;
		int n, ti, pd;
		ti = 0;
		pd = 0;
		wr(8'h0c, 32'h8, r);
		lights <= 1'b1;
		wr(8'h00, 32'h1, r);
		wt(0, 50, n);
		wt(1, 200, n);
		chk("pilot_time", near(n, pf() * C), 32'h1);
		for (int t = 1; t < mf() * C + 20; t++) begin
			@(posedge aclk);
			if (irq && ti == 0) ti = t;
			if (!pilot && pd == 0) pd = t;
		end
		chk("main_time", near(ti, mf() * C), 32'h1);
		chk("pilot_drop", s2 ? pd : near(pd, (link ? 30 : 15) * C), s2 ? 0 : 1);
		rd(8'h08, v, r);
		chk("run_irq", v, 32'h8);
		rd(8'h08, v, r);
		chk("irq_clr", {v[3:0], irq}, 5'h0);
		wr(8'h00, 32'h2, r);
		$display("burn test done");
	endtask
	task automatic t_lock;
		logic [31:0] v;
		logic [1:0] r;
		int n;
		wr(8'h0c, 32'h4, r);
		s3 <= 1'b0;
		wt(2, 30, n);
		chk("strap_irq", {irq, lock, il_en}, 3'b100);
		rd(8'h08, v, r);
		s3 <= 1'b1;
		wr(8'h0c, 32'h2, r);
		wr(8'h00, 32'h1, r);
		wt(1, 200, n);
		repeat (410 * C) @(posedge aclk);
		rd(8'h14, v, r);
		chk("runtime", {v > 32'h190, lock}, 2'h2);
		s1 <= 1'b0;
		wt(4, 30, n);
		chk("lock", {lock, irq, main}, 3'b110);
		rd(8'h04, v, r);
		chk("fault", {v[15:8], v[6]}, {8'h6e, 1'b1});
		$display("lockout test done");
	endtask
	initial begin
		rnd = xs(rnd);
		boot(1'b0, 1'b0, 1'b0, rnd[0]);
		t_cfg;
		t_noflame;
		t_burn;
		// other blower link state, so both interrupted pilot timings run
		link <= ~link;
		t_burn;
		rnd = xs(rnd);
		boot(1'b1, 1'b1, 1'b1, rnd[0]);
		t_cfg;
		t_noflame;
		t_burn;
		t_lock;
		end_sim;
	end
	initial begin
		repeat (30000) @(posedge aclk);
		fail_count++;
		$display("Error watchdog expected finish seen hang");
		end_sim;
	end
endmodule // tb_top
